/* File: hdl/pbsp_port.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Pipelined burst SRAM port: input registers, burst logic, array, output
module pbsp_port
	import pbsp_pkg::*;
#(
	// Defaults give 256K x 36; use 19 and 2 for 512K x 18
	parameter int ADDR_W = PBSP_ADDR_W_X36,
	parameter int LANES = PBSP_LANES_X36
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Address and strobes
	input wire logic [ADDR_W-1:0] addr,
	input wire logic processor_address_strobe_n,
	input wire logic controller_address_strobe_n,
	input wire logic burst_advance_n,
	input wire logic burst_linear,
	// Chip selects
	input wire logic pipeline_chip_select_n,
	input wire logic depth_chip_select_high,
	input wire logic depth_chip_select_low_n,
	// Write controls
	input wire logic [LANES-1:0] per_byte_write_select_n,
	input wire logic byte_write_qualifier_n,
	input wire logic global_write_n,
	// Asynchronous controls
	input wire logic output_enable_n,
	input wire logic sleep_request,
	// Data pin, split into input, output and output enable
	input wire logic [LANES*PBSP_LANE_W-1:0] data_in,
	output logic [LANES*PBSP_LANE_W-1:0] data_out,
	output logic data_oe
);
	localparam int DATA_W = LANES * PBSP_LANE_W;
	localparam logic [LANES-1:0] ALL_LANES = {LANES{1'b1}};
	localparam logic [LANES-1:0] NO_LANES = {LANES{1'b0}};

	////////////////////////////////////////////////////////////////////////
	// Input registers
	logic [ADDR_W-1:0] addr_r; // Captured address
	logic [DATA_W-1:0] din_r; // Captured write data
	logic pstb_n_r; // Processor strobe, active low
	logic cstb_n_r; // Controller strobe, active low
	logic step_n_r; // Advance, active low
	logic linear_r; // Burst order select
	logic pipe_sel_n_r; // Pipeline chip select, active low
	logic hi_sel_r; // Depth chip select, active high
	logic lo_sel_n_r; // Depth chip select, active low
	logic [LANES-1:0] bw_n_r; // Per-lane write selects, active low
	logic lane_qual_n_r; // Lane-write qualifier, active low
	logic all_wr_n_r; // Global write, active low

	// Every synchronous pin goes through a register first
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			addr_r <= '0;
			din_r <= '0;
			pstb_n_r <= 1'b1;
			cstb_n_r <= 1'b1;
			step_n_r <= 1'b1;
			linear_r <= 1'b0;
			pipe_sel_n_r <= 1'b1;
			hi_sel_r <= 1'b0;
			lo_sel_n_r <= 1'b1;
			bw_n_r <= ALL_LANES;
			lane_qual_n_r <= 1'b1;
			all_wr_n_r <= 1'b1;
		end else begin
			addr_r <= addr;
			din_r <= data_in;
			pstb_n_r <= processor_address_strobe_n;
			cstb_n_r <= controller_address_strobe_n;
			step_n_r <= burst_advance_n;
			linear_r <= burst_linear;
			pipe_sel_n_r <= pipeline_chip_select_n;
			hi_sel_r <= depth_chip_select_high;
			lo_sel_n_r <= depth_chip_select_low_n;
			bw_n_r <= per_byte_write_select_n;
			lane_qual_n_r <= byte_write_qualifier_n;
			all_wr_n_r <= global_write_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Access decode on the registered inputs
	logic chip_sel; // All three chip selects true
	logic pstb_go; // Processor strobe honoured only with pipeline select
	logic start; // A new access or a deselect begins
	logic write_req; // Write controls ask for a write
	logic [LANES-1:0] lanes_req; // Lanes the write controls name
	logic active_r; // A burst is open
	logic [ADDR_W-1:0] base_r; // Address latched by the strobe
	logic [PBSP_BURST_W-1:0] cnt_r; // Burst counter
	logic [PBSP_BURST_W-1:0] cnt_nxt; // Counter for this beat
	logic [PBSP_BURST_W-1:0] low_beat; // Ordered low address bits
	logic [ADDR_W-1:0] mem_addr; // Address handed to the array
	pbsp_acc_t acc; // Kind of access this cycle

	// Chip selects and start condition
	always_comb begin
		chip_sel = ~pipe_sel_n_r & hi_sel_r & ~lo_sel_n_r;
		pstb_go = ~pstb_n_r & ~pipe_sel_n_r;
		start = pstb_go | ~cstb_n_r;
	end

	// Write lanes: global write overrides the lane selects
	always_comb begin
		if (!all_wr_n_r) begin
			lanes_req = ALL_LANES;
		end else if (!lane_qual_n_r) begin
			lanes_req = ~bw_n_r;
		end else begin
			lanes_req = NO_LANES;
		end
		write_req = lanes_req != NO_LANES;
	end

	// Counter clears on a start, steps under advance; held otherwise (burst suspend)
	always_comb begin
		if (start) begin
			cnt_nxt = PBSP_CNT_ZERO;
		end else if (!step_n_r) begin
			cnt_nxt = cnt_r + PBSP_CNT_STEP;
		end else begin
			cnt_nxt = cnt_r;
		end
	end

	// Order of beats within four: linear adds, interleaved xors
	always_comb begin
		if (linear_r) begin
			low_beat = base_r[PBSP_BURST_W-1:0] + cnt_nxt;
		end else begin
			low_beat = base_r[PBSP_BURST_W-1:0] ^ cnt_nxt;
		end
		if (start) begin
			mem_addr = addr_r;
		end else begin
			mem_addr = {base_r[ADDR_W-1:PBSP_BURST_W], low_beat};
		end
	end

	// Pick read, write or nothing; sleep blocks any array access
	always_comb begin
		acc = PBSP_ACC_IDLE;
		if (sleep_request) begin
			acc = PBSP_ACC_IDLE;
		end else if (start) begin
			if (!chip_sel) begin
				acc = PBSP_ACC_IDLE; // Deselect
			end else if (pstb_go) begin
				// Write controls are not looked at on a processor start
				acc = PBSP_ACC_READ;
			end else if (write_req) begin
				acc = PBSP_ACC_WRITE;
			end else begin
				acc = PBSP_ACC_READ;
			end
		end else if (active_r) begin
			acc = write_req ? PBSP_ACC_WRITE : PBSP_ACC_READ;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Burst state
	// Strobe latches base address and opens or closes the burst
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			active_r <= 1'b0;
			base_r <= '0;
		end else if (start && !sleep_request) begin
			active_r <= chip_sel;
			base_r <= addr_r;
		end
	end

	// Counter register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_r <= PBSP_CNT_ZERO;
		end else if (!sleep_request) begin
			cnt_r <= cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Storage array; the write lands one edge after capture
	logic [LANES-1:0] wr_lanes; // Lanes written this cycle
	logic rd_en; // Read this cycle
	logic [DATA_W-1:0] rd_data; // Registered array output

	always_comb begin
		wr_lanes = (acc == PBSP_ACC_WRITE) ? lanes_req : NO_LANES;
		rd_en = acc == PBSP_ACC_READ;
	end

	// Lane width holds eight data bits and a parity bit
	pbsp_array #(
		.ADDR_W(ADDR_W),
		.LANES(LANES)
	) u_array (
		.sys_clk(sys_clk),
		.addr(mem_addr),
		.rd_en(rd_en),
		.wr_lanes(wr_lanes),
		.wr_data(din_r),
		.rd_data(rd_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Read pipeline: array register, then output register
	logic rd_valid_r; // Array read data is fresh
	logic drive_r; // Output register holds read data to drive

	// Valid flag trails the array read by one edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_valid_r <= 1'b0;
			drive_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_en;
			drive_r <= rd_valid_r; // Ends two cycles after deselect
		end
	end

	// Output data register; keeps last word when nothing new comes
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			data_out <= '0;
		end else if (rd_valid_r) begin
			data_out <= rd_data;
		end
	end

	// Output enable and sleep gate the drive with no clock in between;
	// this is the one output that is not a plain flip-flop
	always_comb begin
		data_oe = drive_r & ~output_enable_n & ~sleep_request;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_START_LATCH: assert property (
		@(posedge sys_clk) disable iff (rst)
		(start && chip_sel && !sleep_request) |=>
			(active_r && base_r == $past(addr_r) && cnt_r == PBSP_CNT_ZERO))
		else $error("strobe did not latch address");

	AST_COUNT_STEP: assert property (
		@(posedge sys_clk) disable iff (rst)
		(!start && !step_n_r && !sleep_request) |=>
			(cnt_r == $past(cnt_r) + PBSP_CNT_STEP))
		else $error("burst counter did not step");

	AST_COUNT_HOLD: assert property (
		@(posedge sys_clk) disable iff (rst)
		(!start && step_n_r) |=> $stable(cnt_r))
		else $error("burst counter moved without advance");

	AST_ORDER: assert property (
		@(posedge sys_clk) disable iff (rst)
		!start |-> (mem_addr[ADDR_W-1:PBSP_BURST_W] ==
			base_r[ADDR_W-1:PBSP_BURST_W] && cnt_nxt == (linear_r ?
			PBSP_BURST_W'(mem_addr[PBSP_BURST_W-1:0] -
			base_r[PBSP_BURST_W-1:0]) :
			(mem_addr[PBSP_BURST_W-1:0] ^
			base_r[PBSP_BURST_W-1:0]))))
		else $error("burst order wrong");

	AST_GLOBAL_WRITE: assert property (
		@(posedge sys_clk) disable iff (rst)
		(acc == PBSP_ACC_WRITE && !all_wr_n_r) |-> (wr_lanes == ALL_LANES))
		else $error("global write missed a lane");

	AST_LANE_WRITE: assert property (
		@(posedge sys_clk) disable iff (rst)
		(acc == PBSP_ACC_WRITE && all_wr_n_r) |-> (wr_lanes == ~bw_n_r))
		else $error("lane write touched wrong lanes");

	AST_WRITE_CAPTURE: assert property (
		@(posedge sys_clk) disable iff (rst)
		(!controller_address_strobe_n && processor_address_strobe_n &&
			!global_write_n && !sleep_request) |=>
			(sleep_request || !chip_sel || acc == PBSP_ACC_WRITE))
		else $error("sampled write not performed");

	AST_READ_LATENCY: assert property (
		@(posedge sys_clk) disable iff (rst)
		(acc == PBSP_ACC_READ) |=> rd_valid_r ##1 drive_r)
		else $error("read pipeline latency wrong");

	AST_DESELECT: assert property (
		@(posedge sys_clk) disable iff (rst)
		(start && !chip_sel && !sleep_request) |-> ##2 !drive_r)
		else $error("drive kept after deselect");

	AST_ASYNC_OE: assert property (
		@(posedge sys_clk) disable iff (rst)
		(output_enable_n || sleep_request) |-> !data_oe)
		else $error("data driven while disabled");
endmodule : pbsp_port

/* File: hdl/pbsp_pkg.sv */
////////////////////////////////////////////////////////////////////////////
// Shared constants of the pipelined burst SRAM port
package pbsp_pkg;
	// Organisation of 256K words by 36 bits
	localparam int PBSP_ADDR_W_X36 = 18;
	localparam int PBSP_LANES_X36 = 4;
	// Organisation of 512K words by 18 bits
	localparam int PBSP_ADDR_W_X18 = 19;
	localparam int PBSP_LANES_X18 = 2;
	// One lane: eight data bits and one parity bit on top
	localparam int PBSP_LANE_DATA_W = 8;
	localparam int PBSP_LANE_W = 9;
	localparam int PBSP_PARITY_POS = 8;
	// Burst counter
	localparam int PBSP_BURST_W = 2;
	localparam logic [1:0] PBSP_CNT_ZERO = 2'h0;
	localparam logic [1:0] PBSP_CNT_STEP = 2'h1;
	// Pipeline kind of the access decoded this cycle
	typedef enum logic [2:0] {
		PBSP_ACC_IDLE = 3'h1,
		PBSP_ACC_READ = 3'h2,
		PBSP_ACC_WRITE = 3'h4
	} pbsp_acc_t;
endpackage : pbsp_pkg

/* File: hdl/pbsp_array.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Byte-lane storage array with registered read data
module pbsp_array
	import pbsp_pkg::*;
#(
	parameter int ADDR_W = PBSP_ADDR_W_X36,
	parameter int LANES = PBSP_LANES_X36
) (
	// Clock
	input wire logic sys_clk,
	// Access port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic rd_en,
	input wire logic [LANES-1:0] wr_lanes,
	input wire logic [LANES*PBSP_LANE_W-1:0] wr_data,
	// Read data, one cycle after the address
	output logic [LANES*PBSP_LANE_W-1:0] rd_data
);
	localparam int DEPTH = 1 << ADDR_W;

	////////////////////////////////////////////////////////////////////////
	// One storage column per lane, so unselected lanes are never touched
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic [PBSP_LANE_W-1:0] mem [DEPTH];
			// Write only the lanes asked for
			always_ff @(posedge sys_clk) begin
				if (wr_lanes[g]) begin
					mem[addr] <= wr_data[g*PBSP_LANE_W +: PBSP_LANE_W];
				end
			end
			// Read data held in a register; holds when not reading
			always_ff @(posedge sys_clk) begin
				if (rd_en) begin
					rd_data[g*PBSP_LANE_W +: PBSP_LANE_W] <= mem[addr];
				end
			end
		end
	endgenerate
endmodule : pbsp_array

/* File: verif/pbsp_host.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Bus master model: one bus cycle per call, driven just after a rising edge
module pbsp_host (
	// Clock
	input wire logic sys_clk,
	// Address and burst controls
	output logic [17:0] addr,
	output logic controller_address_strobe_n,
	output logic processor_address_strobe_n,
	output logic burst_advance_n,
	// Chip selects
	output logic pipeline_chip_select_n,
	output logic depth_chip_select_high,
	output logic depth_chip_select_low_n,
	// Write controls and write data
	output logic global_write_n,
	output logic byte_write_qualifier_n,
	output logic [3:0] per_byte_write_select_n,
	output logic [35:0] data_in
);
	// Single bank, so the depth selects stay on
	assign depth_chip_select_high = 1'b1;
	assign depth_chip_select_low_n = 1'b0;

	// Quiet bus at time zero
	initial begin
		addr = 18'h0;
		data_in = 36'h0;
		{controller_address_strobe_n, processor_address_strobe_n} = 2'h3;
		{burst_advance_n, pipeline_chip_select_n} = 2'h3;
		{global_write_n, byte_write_qualifier_n} = 2'h3;
		per_byte_write_select_n = 4'hF;
	end

	// c = strobe_c, strobe_p, advance, pipeline select (all active low)
	// w = global, qualifier, lane selects (all active low)
	task automatic beat(input logic [3:0] c, input logic [5:0] w,
			input logic [17:0] a, input logic [35:0] d);
		@(posedge sys_clk);
		{controller_address_strobe_n, processor_address_strobe_n,
			burst_advance_n, pipeline_chip_select_n} <= c;
		{global_write_n, byte_write_qualifier_n,
			per_byte_write_select_n} <= w;
		// Held a whole cycle, so it stands at the sampling edge
		addr <= a;
		// Unused data is inverted so a stale word never looks right
		data_in <= (w == 6'h3F) ? ~data_in : d;
	endtask : beat
endmodule : pbsp_host

/* File: verif/pbsp_port_test.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Self-checking bench of the burst SRAM port
module pbsp_port_test;
	// Clock, reset, burst order and asynchronous pins
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic burst_linear = 1'b1;
	logic output_enable_n = 1'b0;
	logic sleep_request = 1'b0;
	// Bus from the master model
	logic [17:0] addr;
	logic controller_address_strobe_n, processor_address_strobe_n;
	logic burst_advance_n, pipeline_chip_select_n;
	logic depth_chip_select_high, depth_chip_select_low_n;
	logic global_write_n, byte_write_qualifier_n;
	logic [3:0] per_byte_write_select_n;
	logic [35:0] data_in, data_out;
	logic data_oe;
	// Tallies
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	pbsp_host u_pbsp_host (.sys_clk, .addr, .controller_address_strobe_n,
		.processor_address_strobe_n, .burst_advance_n,
		.pipeline_chip_select_n, .depth_chip_select_high,
		.depth_chip_select_low_n, .global_write_n, .byte_write_qualifier_n,
		.per_byte_write_select_n, .data_in);
	pbsp_port u_pbsp_port (.sys_clk, .rst, .addr,
		.processor_address_strobe_n, .controller_address_strobe_n,
		.burst_advance_n, .burst_linear, .pipeline_chip_select_n,
		.depth_chip_select_high, .depth_chip_select_low_n,
		.per_byte_write_select_n, .byte_write_qualifier_n, .global_write_n,
		.output_enable_n, .sleep_request, .data_in, .data_out, .data_oe);

	// 25 MHz clock
	always #20 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////
	// Verdict and comparison
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	task automatic check(input string name, input logic [35:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check

	// Hang guard, far above the fifty or so cycles the tests need
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			stop_test();
		end
	end

	// Write pattern of beat k
	function automatic logic [35:0] wd(input int k);
		return 36'h9_8765_4320 + 36'(k);
	endfunction : wd

	////////////////////////////////////////////////////////////////////////
	// Four-beat write burst, then deselect
	task automatic wr4(input logic [17:0] a, input logic [5:0] w, input int k);
		u_pbsp_host.beat(4'h6, w, a, wd(k));
		for (int i = 1; i < 4; i++) u_pbsp_host.beat(4'hC, w, a, wd(k + i));
		u_pbsp_host.beat(4'h7, 6'h3F, a, 36'h0);
	endtask : wr4

	// Four-beat read, deselect after the last advance; 3-1-1-1 timing
	task automatic rd4(input logic [3:0] c, input logic [17:0] a,
			input logic [35:0] e [4]);
		u_pbsp_host.beat(c, 6'h3F, a, 36'h0);
		for (int i = 0; i < 7; i++) begin
			u_pbsp_host.beat(i < 3 ? 4'hC : (i == 3 ? 4'h7 : 4'hF),
				6'h3F, a, 36'h0);
			#1;
			if (i >= 2 && i < 6) begin
				check("read word", data_out, e[i-2]);
				check("drive on", 36'(data_oe), 36'h1);
			end
		end
		check("drive off", 36'(data_oe), 36'h0);
	endtask : rd4

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		check("reset drive", 36'(data_oe), 36'h0);
		// Linear global write at base 101: 101 102 103 100
		wr4(18'h101, 6'h1F, 0);
		@(posedge sys_clk) burst_linear <= 1'b0;
		rd4(4'h6, 18'h101, '{wd(0), wd(3), wd(2), wd(1)});
		@(posedge sys_clk) burst_linear <= 1'b1;
		rd4(4'h6, 18'h102, '{wd(1), wd(2), wd(3), wd(0)});
		// Lanes 0 and 2 cleared, lanes 1 and 3 kept
		u_pbsp_host.beat(4'h6, 6'h2A, 18'h100, 36'h0);
		u_pbsp_host.beat(4'h7, 6'h3F, 18'h100, 36'h0);
		rd4(4'hA, 18'h100, '{wd(3) & ~36'h0_07FC_01FF, wd(0), wd(1),
			wd(2)});
		// Suspended read; a processor strobe without pipeline select
		// must neither restart nor close the open burst
		u_pbsp_host.beat(4'h6, 6'h3F, 18'h102, 36'h0);
		u_pbsp_host.beat(4'hB, 6'h3F, 18'h101, 36'h0);
		repeat (2) u_pbsp_host.beat(4'hE, 6'h3F, 18'h102, 36'h0);
		#1;
		check("suspend word", data_out, wd(1));
		u_pbsp_host.beat(4'hE, 6'h3F, 18'h102, 36'h0);
		#1;
		check("ignored strobe", 36'(data_oe), 36'h1);
		// Then the asynchronous pins cut the drive
		u_pbsp_host.beat(4'hE, 6'h3F, 18'h102, 36'h0);
		output_enable_n <= 1'b1;
		#1;
		check("enable off", 36'(data_oe), 36'h0);
		u_pbsp_host.beat(4'hE, 6'h3F, 18'h102, 36'h0);
		output_enable_n <= 1'b0;
		sleep_request <= 1'b1;
		#1;
		check("sleep off", 36'(data_oe), 36'h0);
		u_pbsp_host.beat(4'h7, 6'h3F, 18'h102, 36'h0);
		sleep_request <= 1'b0;
		repeat (3) u_pbsp_host.beat(4'hF, 6'h3F, 18'h102, 36'h0);
		stop_test();
	end
endmodule : pbsp_port_test
